// ===== core/sadc_top.sv
// Operation
// R1: result is 12 bits held over high and low bytes, readable directly.
// R2: justify 0: high byte gets bits 11..4, low upper nibble bits 3..0.
// R3: justify 1: high low nibble bits 11..8, low byte bits 7..0; rest zero.
// R4: converter disabled keeps both result bytes unchanged.
// R5: start bit written high then low launches a conversion.
// R6: busy flag sets on launch, clears when conversion completes.
// R7: enable bit powers converter; cleared switches it off.
// R8: twelve-channel variant: codes 0..11 select inputs, 12..15 float.
// R9: nine-channel variant: codes 0..8 select inputs, 9..15 float.
// R10: source field picks external, supply fractions, amplifier fractions or ground.
// R11: internal source always disconnects the external channel path.
// R12: clock field divides system clock by 1 to 128 in powers of two.
// R13: control b bit 3 reads zero, writes ignored.
// R14: pin chosen as analog input loses shared function and pull-high.
// R15: software reads results only after busy returns low.
// R16: control c holds amp enable, amp input, reference and gain fields.
// R17: power-on reset clears every implemented control bit.
// R18: result is written no later than the cycle busy clears.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`default_nettype none
module sadc_top #(
    parameter bit NINE_CHANNEL = 1'b0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter core
    input wire logic conv_done,
    input wire logic [11:0] conv_data,
    output logic conv_power_on,
    output logic conv_start,
    output logic conv_clk_en,
    // input routing
    output logic ext_path_on,
    output logic [11:0] ext_ch_connect,
    output logic [11:0] pin_analog_mode,
    output logic [3:0] int_src_code,
    // amplifier and reference
    output logic amp_enable,
    output logic amp_input_sel,
    output logic [1:0] reference_sel,
    output logic [1:0] amp_gain_sel,
    // interrupt
    output logic irq
);

    typedef struct packed {
        // control a fields
        logic start;
        logic busy;
        logic enable;
        logic justify;
        logic [3:0] ext_ch;
        // control b fields
        logic [3:0] src;
        logic [2:0] clkdiv;
        // control c fields
        logic amp_en;
        logic amp_in;
        logic [1:0] ref_sel;
        logic [1:0] gain;
        // result and interrupt state
        logic [11:0] result;
        logic [1:0] sts;
        logic [1:0] mask;
        // conversion clock
        logic [6:0] prescale;
        logic clk_en;
        // converter and routing outputs
        logic cstart;
        logic ext_on;
        logic [11:0] ch_connect;
        logic [11:0] pin_mode;
        logic [3:0] int_code;
        // bus answer and interrupt line
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic irq;
    } sadc_state_s;

    sadc_state_s s;
    sadc_state_s next_s;

    // variant sets the highest channel code that reaches a pin
    logic [3:0] max_ch;
    assign max_ch = NINE_CHANNEL ? sadc_pkg::MAX_CH_NINE : sadc_pkg::MAX_CH_TWELVE;

    always_comb begin
        logic setup;
        logic wr;
        logic rd;
        logic hit;
        logic launch;
        logic internal;
        logic chan_ok;
        logic [6:0] div_mask;
        logic [7:0] res_hi;
        logic [7:0] res_lo;
        logic [7:0] rval;
        logic [11:0] ch_onehot;
        setup = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        hit = 1'b0;
        launch = 1'b0;
        internal = 1'b0;
        chan_ok = 1'b0;
        div_mask = 7'h00;
        res_hi = 8'h00;
        res_lo = 8'h00;
        rval = 8'h00;
        ch_onehot = 12'h000;
        next_s = s;
        next_s.cstart = 1'b0;

        setup = psel & ~penable;
        wr = psel & penable & s.ready & pwrite;
        rd = psel & penable & s.ready & ~pwrite;

        // result view depends on the current justification
        if (s.justify) begin
            res_hi = {4'h0, s.result[11:8]}; // [R3]
            res_lo = s.result[7:0]; // [R3]
        end else begin
            res_hi = s.result[11:4]; // [R2]
            res_lo = {s.result[3:0], 4'h0}; // [R2]
        end

        case (paddr)
            sadc_pkg::OFS_RES_HIGH: begin
                hit = 1'b1;
                rval = res_hi; // [R1]
            end
            sadc_pkg::OFS_RES_LOW: begin
                hit = 1'b1;
                rval = res_lo; // [R1]
            end
            sadc_pkg::OFS_CTRL_A: begin
                hit = 1'b1;
                rval[sadc_pkg::BIT_START] = s.start;
                rval[sadc_pkg::BIT_BUSY] = s.busy;
                rval[sadc_pkg::BIT_ENABLE] = s.enable;
                rval[sadc_pkg::BIT_JUSTIFY] = s.justify;
                rval[sadc_pkg::POS_EXT_CH +: 4] = s.ext_ch;
            end
            sadc_pkg::OFS_CTRL_B: begin
                hit = 1'b1;
                // bit 3 keeps its cleared value [R13]
                rval[sadc_pkg::POS_SRC +: 4] = s.src;
                rval[sadc_pkg::POS_CLKDIV +: 3] = s.clkdiv;
            end
            sadc_pkg::OFS_CTRL_C: begin
                hit = 1'b1;
                rval[sadc_pkg::BIT_AMP_EN] = s.amp_en; // [R16]
                rval[sadc_pkg::BIT_AMP_IN] = s.amp_in; // [R16]
                rval[sadc_pkg::POS_REF +: 2] = s.ref_sel; // [R16]
                rval[sadc_pkg::POS_GAIN +: 2] = s.gain; // [R16]
            end
            sadc_pkg::OFS_INT_STATUS: begin
                hit = 1'b1;
                rval = {6'h00, s.sts};
            end
            sadc_pkg::OFS_INT_MASK: begin
                hit = 1'b1;
                rval = {6'h00, s.mask};
            end
            default: begin
                hit = 1'b0;
                rval = 8'h00;
            end
        endcase

        // zero wait state: answer registered during setup, shown in access
        next_s.ready = setup;
        next_s.slverr = setup & ~hit;
        next_s.rdata = (setup & ~pwrite) ? {24'h000000, rval} : 32'h00000000;

        if (wr) begin
            case (paddr)
                sadc_pkg::OFS_CTRL_A: begin
                    next_s.start = pwdata[sadc_pkg::BIT_START];
                    launch = s.start & ~pwdata[sadc_pkg::BIT_START]; // [R5]
                    next_s.enable = pwdata[sadc_pkg::BIT_ENABLE]; // [R7]
                    next_s.justify = pwdata[sadc_pkg::BIT_JUSTIFY];
                    next_s.ext_ch = pwdata[sadc_pkg::POS_EXT_CH +: 4];
                end
                sadc_pkg::OFS_CTRL_B: begin
                    next_s.src = pwdata[sadc_pkg::POS_SRC +: 4];
                    next_s.clkdiv = pwdata[sadc_pkg::POS_CLKDIV +: 3]; // [R13]
                end
                sadc_pkg::OFS_CTRL_C: begin
                    next_s.amp_en = pwdata[sadc_pkg::BIT_AMP_EN]; // [R16]
                    next_s.amp_in = pwdata[sadc_pkg::BIT_AMP_IN]; // [R16]
                    next_s.ref_sel = pwdata[sadc_pkg::POS_REF +: 2]; // [R16]
                    next_s.gain = pwdata[sadc_pkg::POS_GAIN +: 2]; // [R16]
                end
                sadc_pkg::OFS_RES_HIGH, sadc_pkg::OFS_RES_LOW: begin
                    // result bytes only change on a finished conversion
                    next_s.result = s.result;
                end
                sadc_pkg::OFS_INT_STATUS: begin
                    // status bits only clear by reading
                    next_s.sts = s.sts;
                end
                sadc_pkg::OFS_INT_MASK: begin
                    next_s.mask = pwdata[1:0];
                end
                default: begin
                    next_s.mask = next_s.mask;
                end
            endcase
        end

        // clear only what the read reported; later events still set
        if (rd && paddr == sadc_pkg::OFS_INT_STATUS) begin
            next_s.sts = s.sts & ~s.rdata[1:0];
        end

        // a refused launch is flagged, never queued
        if (launch) begin
            if (s.enable && !s.busy) begin
                next_s.busy = 1'b1; // [R6]
                next_s.cstart = 1'b1; // [R5]
            end else begin
                next_s.sts[sadc_pkg::BIT_IRQ_REFUSED] = 1'b1;
            end
        end

        if (s.busy) begin
            if (!s.enable) begin
                // aborted by power-down: old result stays
                next_s.busy = 1'b0; // [R4]
            end else if (conv_done) begin
                next_s.result = conv_data; // [R18]
                next_s.busy = 1'b0; // [R6]
                next_s.sts[sadc_pkg::BIT_IRQ_DONE] = 1'b1;
            end
        end

        // conversion clock prescaler
        // free-running count: every ratio's period divides its wrap
        case (s.clkdiv)
            3'h0: div_mask = 7'h00;
            3'h1: div_mask = 7'h01;
            3'h2: div_mask = 7'h03;
            3'h3: div_mask = 7'h07;
            3'h4: div_mask = 7'h0f;
            3'h5: div_mask = 7'h1f;
            3'h6: div_mask = 7'h3f;
            3'h7: div_mask = 7'h7f;
            default: div_mask = 7'h7f;
        endcase
        if (s.enable) begin
            next_s.prescale = s.prescale + 7'h01;
            next_s.clk_en = (s.prescale & div_mask) == div_mask; // [R12]
        end else begin
            next_s.prescale = 7'h00;
            next_s.clk_en = 1'b0; // [R7]
        end

        // source decode: 0000, 0100 and 11xx are external
        case (s.src)
            4'h0, 4'h4: begin
                internal = 1'b0; // [R10]
            end
            // supply, half supply, quarter supply
            4'h1, 4'h2, 4'h3: begin
                internal = 1'b1; // [R10]
            end
            // amplifier output, half, quarter
            4'h5, 4'h6, 4'h7: begin
                internal = 1'b1; // [R10]
            end
            // tied to ground
            4'h8, 4'h9, 4'ha, 4'hb: begin
                internal = 1'b1; // [R10]
            end
            default: begin
                internal = 1'b0; // [R10]
            end
        endcase
        chan_ok = s.ext_ch <= max_ch; // [R8] [R9]
        // one pin per code; codes past the last pin select nothing
        case (s.ext_ch)
            4'h0: begin
                ch_onehot = 12'h001;
            end
            4'h1: begin
                ch_onehot = 12'h002;
            end
            4'h2: begin
                ch_onehot = 12'h004;
            end
            4'h3: begin
                ch_onehot = 12'h008;
            end
            4'h4: begin
                ch_onehot = 12'h010;
            end
            4'h5: begin
                ch_onehot = 12'h020;
            end
            4'h6: begin
                ch_onehot = 12'h040;
            end
            4'h7: begin
                ch_onehot = 12'h080;
            end
            4'h8: begin
                ch_onehot = 12'h100;
            end
            4'h9: begin
                ch_onehot = 12'h200;
            end
            4'ha: begin
                ch_onehot = 12'h400;
            end
            4'hb: begin
                ch_onehot = 12'h800;
            end
            default: begin
                ch_onehot = 12'h000;
            end
        endcase
        next_s.ext_on = s.enable & ~internal & chan_ok; // [R11]
        next_s.ch_connect = next_s.ext_on ? ch_onehot : 12'h000; // [R11]
        // analog pins drop digital function and pull-high
        next_s.pin_mode = (chan_ok & ~internal) ? ch_onehot : 12'h000; // [R14]
        next_s.int_code = (s.enable & internal) ? s.src : 4'h0; // [R10]

        next_s.irq = |(next_s.sts & next_s.mask);
    end

    // every field clears asynchronously so outputs sit low through reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.busy <= sadc_pkg::RST_CTRL_A[sadc_pkg::BIT_BUSY]; // [R17]
            s.justify <= sadc_pkg::RST_CTRL_A[sadc_pkg::BIT_JUSTIFY]; // [R17]
            s.amp_in <= sadc_pkg::RST_CTRL_C[sadc_pkg::BIT_AMP_IN];
            s.ref_sel <= sadc_pkg::RST_CTRL_C[sadc_pkg::POS_REF +: 2];
            s.gain <= sadc_pkg::RST_CTRL_C[sadc_pkg::POS_GAIN +: 2];
            s.start <= sadc_pkg::RST_CTRL_A[sadc_pkg::BIT_START]; // [R17]
            s.enable <= sadc_pkg::RST_CTRL_A[sadc_pkg::BIT_ENABLE]; // [R17]
            s.ext_ch <= sadc_pkg::RST_CTRL_A[3:0]; // [R17]
            s.src <= sadc_pkg::RST_CTRL_B[7:4]; // [R17]
            s.clkdiv <= sadc_pkg::RST_CTRL_B[2:0]; // [R17]
            s.amp_en <= sadc_pkg::RST_CTRL_C[sadc_pkg::BIT_AMP_EN];
            s.result <= sadc_pkg::RST_RESULT;
            s.sts <= sadc_pkg::RST_IRQ;
            s.mask <= sadc_pkg::RST_IRQ;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.rdata;
    assign pready = s.ready;
    assign pslverr = s.slverr;
    assign conv_power_on = s.enable; // [R7]
    assign conv_start = s.cstart;
    assign conv_clk_en = s.clk_en;
    assign ext_path_on = s.ext_on;
    assign ext_ch_connect = s.ch_connect;
    assign pin_analog_mode = s.pin_mode;
    assign int_src_code = s.int_code;
    assign amp_enable = s.amp_en;
    assign amp_input_sel = s.amp_in;
    assign reference_sel = s.ref_sel;
    assign amp_gain_sel = s.gain;
    assign irq = s.irq;

endmodule
`default_nettype wire

// ===== core/sadc_pkg.sv
`default_nettype none
package sadc_pkg;
    // apb byte offsets
    localparam logic [11:0] OFS_RES_HIGH = 12'h000;
    localparam logic [11:0] OFS_RES_LOW = 12'h004;
    localparam logic [11:0] OFS_CTRL_A = 12'h008;
    localparam logic [11:0] OFS_CTRL_B = 12'h00c;
    localparam logic [11:0] OFS_CTRL_C = 12'h010;
    localparam logic [11:0] OFS_INT_STATUS = 12'h014;
    localparam logic [11:0] OFS_INT_MASK = 12'h018;
    // conv_control_a fields
    localparam int BIT_START = 7;
    localparam int BIT_BUSY = 6;
    localparam int BIT_ENABLE = 5;
    localparam int BIT_JUSTIFY = 4;
    localparam int POS_EXT_CH = 0;
    // conv_control_b fields
    localparam int POS_SRC = 4;
    localparam int POS_CLKDIV = 0;
    // conv_control_c fields
    localparam int BIT_AMP_EN = 7;
    localparam int BIT_AMP_IN = 4;
    localparam int POS_REF = 2;
    localparam int POS_GAIN = 0;
    // interrupt status bits
    localparam int BIT_IRQ_DONE = 0;
    localparam int BIT_IRQ_REFUSED = 1;
    // reset values
    localparam logic [7:0] RST_CTRL_A = 8'h00;
    localparam logic [7:0] RST_CTRL_B = 8'h00;
    localparam logic [7:0] RST_CTRL_C = 8'h00;
    localparam logic [11:0] RST_RESULT = 12'h000;
    localparam logic [1:0] RST_IRQ = 2'h0;
    // highest channel codes per variant
    localparam logic [3:0] MAX_CH_TWELVE = 4'hb;
    localparam logic [3:0] MAX_CH_NINE = 4'h8;
endpackage
`default_nettype wire

// ===== test/sadc_chk_sva.sv
`default_nettype none
module sadc_chk (
    // bus
    input wire logic pclk, presetn, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic pready, pslverr,
    // converter and routing
    input wire logic conv_start, conv_power_on, ext_path_on, irq,
    input wire logic [11:0] ext_ch_connect,
    input wire logic [3:0] int_src_code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic start_q;
    logic wr_a;
    assign wr_a = psel && penable && pready && pwrite && paddr == sadc_pkg::OFS_CTRL_A;
    // stored start bit, so a launch can be tied to the falling write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            start_q <= 1'b0;
        else if (wr_a)
            start_q <= pwdata[7];
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_ready_first: assert property (psel && !penable |=> pready)
        else $error("no ready in first access cycle");
    chk_unmapped_err: assert property (
        pready && paddr > sadc_pkg::OFS_INT_MASK |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_byte_wide: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data above byte not zero");
    chk_start_cause: assert property (
        conv_start |-> $past(wr_a && !pwdata[7] && start_q && conv_power_on))
        else $error("launch without high then low start");
    chk_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("launch pulse too long");
    chk_disable_off: assert property (
        wr_a && !pwdata[5] |-> ##[1:2] !conv_power_on && ext_ch_connect == 12'h0)
        else $error("converter still powered");
    chk_ext_vs_int: assert property (
        ext_path_on |-> int_src_code == 4'h0 && $onehot(ext_ch_connect))
        else $error("external and internal joined");
    chk_ext_idle: assert property (!ext_path_on |-> ext_ch_connect == 12'h0)
        else $error("channel connected while path off");
    chk_src_code: assert property (
        int_src_code != 4'h0 |-> int_src_code != 4'h4 && int_src_code[3:2] != 2'b11)
        else $error("external code shown as internal");
    cover property (conv_start);
    cover property (pslverr);
    cover property (irq);
endmodule
bind sadc_top sadc_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .conv_start, .conv_power_on, .ext_path_on, .irq,
    .ext_ch_connect, .int_src_code);
`default_nettype wire

// ===== test/sadc_top_test.sv
`default_nettype none
module sadc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic conv_done = 1'b0;
    logic [11:0] paddr = 12'h000, conv_data = 12'h000, ext_ch_connect, pin_analog_mode;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, conv_power_on, conv_start, conv_clk_en, ext_path_on, irq, err;
    logic amp_enable, amp_input_sel, ext;
    logic [1:0] reference_sel, amp_gain_sel;
    logic [3:0] int_src_code;
    logic [11:0] ext_ch_connect9;
    int n_mismatch = 0, samples_checked = 0, cyc = 0, starts = 0, cnt;
    sadc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .conv_done, .conv_data, .conv_power_on, .conv_start, .conv_clk_en,
        .ext_path_on, .ext_ch_connect, .pin_analog_mode, .int_src_code, .amp_enable,
        .amp_input_sel, .reference_sel, .amp_gain_sel, .irq);
    sadc_top #(.NINE_CHANNEL(1'b1)) dut9 (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata(), .pready(), .pslverr(), .conv_done, .conv_data, .conv_power_on(),
        .conv_start(), .conv_clk_en(), .ext_path_on(), .ext_ch_connect(ext_ch_connect9),
        .pin_analog_mode(), .int_src_code(), .amp_enable(), .amp_input_sel(),
        .reference_sel(), .amp_gain_sel(), .irq());
    initial forever #10 pclk = ~pclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one full transfer, then a spare edge so psel is never reassigned in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && cyc < 9000);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    task automatic done_pulse(input logic [11:0] v);
        {conv_done, conv_data} <= {1'b1, v};
        @(posedge pclk);
        conv_done <= 1'b0;
        @(posedge pclk);
    endtask
    // counted between edges so a compare at the next edge sees the pulse
    always @(negedge pclk) begin
        cyc++;
        if (conv_start === 1'b1)
            starts++;
        if (cyc > 10000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(sadc_pkg::OFS_CTRL_A, 32'h0);
        rdchk(sadc_pkg::OFS_CTRL_B, 32'h0);
        apb(1'b1, sadc_pkg::OFS_CTRL_B, 32'hff);
        rdchk(sadc_pkg::OFS_CTRL_B, 32'hf7);
        apb(1'b1, sadc_pkg::OFS_CTRL_C, 32'h9f);
        rdchk(sadc_pkg::OFS_CTRL_C, 32'h9f);
        check({amp_enable, amp_input_sel, reference_sel, amp_gain_sel}, 6'h3f);
        apb(1'b1, sadc_pkg::OFS_INT_MASK, 32'h3);
        apb(1'b1, sadc_pkg::OFS_CTRL_A, 32'ha0);
        apb(1'b1, sadc_pkg::OFS_CTRL_A, 32'h20);
        check(starts, 1);
        rdchk(sadc_pkg::OFS_CTRL_A, 32'h60);
        done_pulse(12'habc);
        rdchk(sadc_pkg::OFS_CTRL_A, 32'h20);
        check(irq, 1'b1);
        rdchk(sadc_pkg::OFS_RES_HIGH, 32'hab);
        rdchk(sadc_pkg::OFS_RES_LOW, 32'hc0);
        apb(1'b1, sadc_pkg::OFS_CTRL_A, 32'h30);
        rdchk(sadc_pkg::OFS_RES_HIGH, 32'h0a);
        rdchk(sadc_pkg::OFS_RES_LOW, 32'hbc);
        rdchk(sadc_pkg::OFS_INT_STATUS, 32'h1);
        rdchk(sadc_pkg::OFS_INT_STATUS, 32'h0);
        check(irq, 1'b0);
        // launch while disabled is refused, and the result must survive
        apb(1'b1, sadc_pkg::OFS_CTRL_A, 32'h90);
        apb(1'b1, sadc_pkg::OFS_CTRL_A, 32'h10);
        done_pulse(12'h123);
        rdchk(sadc_pkg::OFS_RES_LOW, 32'hbc);
        rdchk(sadc_pkg::OFS_INT_STATUS, 32'h2);
        check(starts, 1);
        check(conv_power_on, 1'b0);
        rdchk(12'h01c, 32'h0);
        check(err, 1'b1);
        apb(1'b1, sadc_pkg::OFS_CTRL_B, 32'h00);
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, sadc_pkg::OFS_CTRL_A, 32'h20 | i);
            @(posedge pclk);
            check(ext_ch_connect, i < 12 ? 12'h001 << i : 12'h000);
            check(ext_ch_connect9, i < 9 ? 12'h001 << i : 12'h000);
        end
        apb(1'b1, sadc_pkg::OFS_CTRL_A, 32'h23);
        for (int s = 0; s < 16; s++) begin
            apb(1'b1, sadc_pkg::OFS_CTRL_B, s << 4);
            @(posedge pclk);
            ext = s == 0 || s == 4 || s >= 12;
            check(ext_path_on, ext);
            check(int_src_code, ext ? 4'h0 : 4'(s));
            check(pin_analog_mode, ext ? 12'h008 : 12'h000);
        end
        // period must divide the window, so the count is exact at any phase
        for (int d = 0; d < 8; d++) begin
            apb(1'b1, sadc_pkg::OFS_CTRL_B, d);
            repeat (3) @(posedge pclk);
            cnt = 0;
            repeat (256) @(posedge pclk) cnt += (conv_clk_en === 1'b1);
            check(cnt, 256 >> d);
        end
        apb(1'b1, sadc_pkg::OFS_CTRL_A, 32'h03);
        @(posedge pclk);
        check({conv_power_on, ext_ch_connect}, 13'h0);
        close_out();
    end
endmodule
`default_nettype wire
